// File: pwmt_defs.svh
// register offsets, field positions and reset values of the channel timer
`ifndef PWMT_DEFS_SVH
`define PWMT_DEFS_SVH

`define PWMT_OFS_CTRL      8'h00
`define PWMT_OFS_PERIOD    8'h04
`define PWMT_OFS_DUTY      8'h08
`define PWMT_OFS_COUNTER   8'h0C
`define PWMT_OFS_STATUS    8'h10
`define PWMT_OFS_PRESCALE  8'h14

`define PWMT_CTRL_ENABLE   0
`define PWMT_CTRL_POLARITY 1
`define PWMT_CTRL_CENTER   2

`define PWMT_STAT_OUT      0
`define PWMT_STAT_DOWN     1
`define PWMT_STAT_RUN      2

`define PWMT_RST_BYTE      8'h00
`define PWMT_RST_WORD      32'h0000_0000
`define PWMT_CNT_ONE       8'h01

`endif

// File: pwmt_pkg.sv
// types shared by the channel timer files
package pwmt_pkg;
	typedef enum logic [0:0] {
		PWMT_UP   = 1'b0,
		PWMT_DOWN = 1'b1
	} pwmt_dir_t;
endpackage

// File: pwmt_tick_gen.sv
// prescaler: divides ref_clk into a one-cycle tick
`timescale 1ns/10ps
`include "pwmt_defs.svh"
module pwmt_tick_gen (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] divValue,
	input  wire logic       reload,
	output logic            tick
);
	logic [7:0] divCnt_ff;
	logic       tick_ff;

	// tick every divValue+1 cycles; reload restarts the phase at once
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt_ff <= `PWMT_RST_BYTE;
		end else if (reload || divCnt_ff == `PWMT_RST_BYTE) begin
			divCnt_ff <= divValue;
		end else begin
			divCnt_ff <= divCnt_ff - `PWMT_CNT_ONE;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= !reload && divCnt_ff == `PWMT_RST_BYTE;
		end
	end

	assign tick = tick_ff;
endmodule

// File: pwmt_channel_timer.sv
// one pwm channel timer with a classic wishbone register slave
`timescale 1ns/10ps
`include "pwmt_defs.svh"
module pwmt_channel_timer (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             pwmOut
);
	logic                 ack_ff;
	logic [31:0]          rdData_ff;
	logic                 channelEnable_ff;
	logic                 startPolarity_ff;
	logic                 centerAlignSelect_ff;
	logic [7:0]           prescale_ff;
	logic [7:0]           periodBuf_ff;
	logic [7:0]           dutyBuf_ff;
	logic [7:0]           periodAct_ff;
	logic [7:0]           dutyAct_ff;
	logic [7:0]           channelCounter_ff;
	pwmt_pkg::pwmt_dir_t  dir_ff;
	logic                 outQ_ff;
	logic                 run_ff;
	logic                 clrPend_ff;
	logic                 pwmOut_ff;

	logic                 busWr;
	logic                 busRd;
	logic                 lane0;
	logic [7:0]           wrByte;
	logic                 wrCtrl;
	logic                 wrPeriod;
	logic                 wrDuty;
	logic                 wrCounter;
	logic                 wrPrescale;
	logic                 disableEvt;
	logic                 tick;
	logic                 step;
	logic [7:0]           nxt_count;
	pwmt_pkg::pwmt_dir_t  nxt_dir;
	logic                 periodEnd;
	logic                 nxt_outQ;
	logic [31:0]          nxt_rdData;

	// the write takes effect on the edge where the master samples ack
	assign busWr      = ack_ff && wb_cyc_i && wb_stb_i && wb_we_i;
	assign busRd      = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
	assign lane0      = wb_sel_i[0];
	assign wrByte     = wb_dat_i[7:0];

	// one strobe per writable register; writes missing lane 0 or the map are dropped
	always_comb begin
		wrCtrl     = 1'b0;
		wrPeriod   = 1'b0;
		wrDuty     = 1'b0;
		wrCounter  = 1'b0;
		wrPrescale = 1'b0;
		if (busWr && lane0) begin
			unique case (wb_adr_i)
				`PWMT_OFS_CTRL:     wrCtrl     = 1'b1;
				`PWMT_OFS_PERIOD:   wrPeriod   = 1'b1;
				`PWMT_OFS_DUTY:     wrDuty     = 1'b1;
				`PWMT_OFS_COUNTER:  wrCounter  = 1'b1;
				`PWMT_OFS_PRESCALE: wrPrescale = 1'b1;
				default:            wrCtrl     = 1'b0;
			endcase
		end
	end

	assign disableEvt = wrCtrl && channelEnable_ff
		&& !wrByte[`PWMT_CTRL_ENABLE];

	pwmt_tick_gen u_tick (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.divValue (prescale_ff),
		.reload   (wrPrescale),
		.tick     (tick)
	);

	// one ack per request, dropped in the following cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
		end
	end

	always_comb begin
		nxt_rdData = `PWMT_RST_WORD;
		unique case (wb_adr_i)
			`PWMT_OFS_CTRL: begin
				nxt_rdData[`PWMT_CTRL_ENABLE]   = channelEnable_ff;
				nxt_rdData[`PWMT_CTRL_POLARITY] = startPolarity_ff;
				nxt_rdData[`PWMT_CTRL_CENTER]   = centerAlignSelect_ff;
			end
			`PWMT_OFS_PERIOD: nxt_rdData[7:0] = periodBuf_ff;
			`PWMT_OFS_DUTY: nxt_rdData[7:0] = dutyBuf_ff;
			`PWMT_OFS_COUNTER: nxt_rdData[7:0] = channelCounter_ff;
			`PWMT_OFS_STATUS: begin
				nxt_rdData[`PWMT_STAT_OUT]  = pwmOut_ff;
				nxt_rdData[`PWMT_STAT_DOWN] = dir_ff == pwmt_pkg::PWMT_DOWN;
				nxt_rdData[`PWMT_STAT_RUN]  = run_ff;
			end
			`PWMT_OFS_PRESCALE: nxt_rdData[7:0] = prescale_ff;
			default: nxt_rdData = `PWMT_RST_WORD;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdData_ff <= `PWMT_RST_WORD;
		end else if (busRd) begin
			rdData_ff <= nxt_rdData;
		end
	end

	// mode bits; changing alignment while running is left to software
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			channelEnable_ff     <= 1'b0;
			startPolarity_ff     <= 1'b0;
			centerAlignSelect_ff <= 1'b0;
		end else if (wrCtrl) begin
			channelEnable_ff     <= wrByte[`PWMT_CTRL_ENABLE];
			startPolarity_ff     <= wrByte[`PWMT_CTRL_POLARITY];
			centerAlignSelect_ff <= wrByte[`PWMT_CTRL_CENTER];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prescale_ff <= `PWMT_RST_BYTE;
		end else if (wrPrescale) begin
			prescale_ff <= wrByte;
		end
	end

	// enable is only seen at a tick edge so the first cycle is whole
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run_ff <= 1'b0;
		end else if (!channelEnable_ff) begin
			run_ff <= 1'b0;
		end else if (tick) begin
			run_ff <= 1'b1;
		end
	end

	// run_ff falls one edge late; the enable gate stops that extra step
	assign step = tick && run_ff && channelEnable_ff;

	// next count, direction and period end for one tick
	always_comb begin
		nxt_count = channelCounter_ff + `PWMT_CNT_ONE;
		nxt_dir   = dir_ff;
		periodEnd = 1'b0;
		if (periodAct_ff == `PWMT_RST_BYTE) begin
			nxt_count = `PWMT_RST_BYTE;
			periodEnd = 1'b1;
		end else if (!centerAlignSelect_ff) begin
			nxt_dir = pwmt_pkg::PWMT_UP;
			if (nxt_count >= periodAct_ff) begin
				nxt_count = `PWMT_RST_BYTE;
				periodEnd = 1'b1;
			end
		end else if (dir_ff == pwmt_pkg::PWMT_UP) begin
			if (channelCounter_ff >= periodAct_ff) begin
				nxt_count = channelCounter_ff - `PWMT_CNT_ONE;
				nxt_dir   = pwmt_pkg::PWMT_DOWN;
			end
		end else begin
			nxt_count = channelCounter_ff - `PWMT_CNT_ONE;
			if (nxt_count == `PWMT_RST_BYTE) begin
				nxt_dir   = pwmt_pkg::PWMT_UP;
				periodEnd = 1'b1;
			end
		end
	end

	// toggle on duty match; a new period starts from the cleared state
	always_comb begin
		nxt_outQ = periodEnd ? 1'b0 : outQ_ff;
		if (nxt_count == (periodEnd ? dutyBuf_ff : dutyAct_ff)) begin
			nxt_outQ = !nxt_outQ;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			channelCounter_ff <= `PWMT_RST_BYTE;
		end else if (wrCounter) begin
			channelCounter_ff <= `PWMT_RST_BYTE;
		end else if (step) begin
			channelCounter_ff <= nxt_count;
		end else if (tick && clrPend_ff) begin
			channelCounter_ff <= `PWMT_RST_BYTE;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			clrPend_ff <= 1'b0;
		end else if (wrPeriod && !channelEnable_ff
			&& wrByte == `PWMT_RST_BYTE) begin
			clrPend_ff <= 1'b1;
		end else if (tick || wrCounter || channelEnable_ff) begin
			clrPend_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dir_ff <= pwmt_pkg::PWMT_UP;
		end else if (wrCounter) begin
			dir_ff <= pwmt_pkg::PWMT_UP;
		end else if (step) begin
			dir_ff <= nxt_dir;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periodBuf_ff <= `PWMT_RST_BYTE;
			dutyBuf_ff   <= `PWMT_RST_BYTE;
		end else begin
			if (wrPeriod) begin
				periodBuf_ff <= wrByte;
			end
			if (wrDuty) begin
				dutyBuf_ff <= wrByte;
			end
		end
	end

	// active latches: direct while disabled, else only at a load point
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periodAct_ff <= `PWMT_RST_BYTE;
			dutyAct_ff   <= `PWMT_RST_BYTE;
		end else if (wrCounter || disableEvt || (step && periodEnd)) begin
			periodAct_ff <= periodBuf_ff;
			dutyAct_ff   <= dutyBuf_ff;
		end else if (!channelEnable_ff) begin
			if (wrPeriod) begin
				periodAct_ff <= wrByte;
			end
			if (wrDuty) begin
				dutyAct_ff <= wrByte;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			outQ_ff <= 1'b0;
		end else if (wrCounter) begin
			outQ_ff <= dutyBuf_ff == `PWMT_RST_BYTE;
		end else if (step) begin
			outQ_ff <= nxt_outQ;
		end
	end

	// polarity picks q or its inverse, so duty is high or low time
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pwmOut_ff <= 1'b0;
		end else begin
			pwmOut_ff <= outQ_ff ^ startPolarity_ff;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;
	assign pwmOut   = pwmOut_ff;
endmodule

// File: pwmt_channel_timer_monitor.sv
// concurrent checks on the channel timer ports
`timescale 1ns/10ps
module pwmt_channel_timer_monitor (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        pwmOut
);
	logic [2:0] ctrlSh_ff;
	logic [7:0] holdVal_ff;
	logic       holdOk_ff;
	wire logic  rdAck = wb_ack_o && !wb_we_i;
	wire logic  wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// any write may move the count, so only counter reads while disabled with no write between them are compared
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrlSh_ff <= 3'h0;
			holdOk_ff <= 1'h0;
			holdVal_ff <= 8'h00;
		end else begin
			if (wrAck && wb_adr_i == 8'h00)
				ctrlSh_ff <= wb_dat_i[2:0];
			if (wb_ack_o && wb_we_i)
				holdOk_ff <= 1'h0;
			else if (rdAck && wb_adr_i == 8'h0C && !ctrlSh_ff[0]) begin
				holdOk_ff <= 1'h1;
				holdVal_ff <= wb_dat_o[7:0];
			end
		end
	end
	property p_ack_next;
		$rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_no_req;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_no_req: assert property (p_no_req) else $error("ack without request");
	property p_upper;
		rdAck |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_unmapped;
		rdAck && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
	property p_ctrl;
		rdAck && wb_adr_i == 8'h00 |-> wb_dat_o[2:0] == ctrlSh_ff;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback");
	property p_left_up;
		rdAck && wb_adr_i == 8'h10 && !ctrlSh_ff[2] |-> !wb_dat_o[1];
	endproperty
	a_left_up: assert property (p_left_up)
		else $error("left counts down");
	property p_hold;
		rdAck && wb_adr_i == 8'h0C && holdOk_ff && !ctrlSh_ff[0]
			|-> wb_dat_o[7:0] == holdVal_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("held count moved");
endmodule

// File: pwmt_channel_timer_test.sv
// self-checking bench for the channel timer
`timescale 1ns/10ps
module pwmt_channel_timer_test;
	logic        ref_clk, resetn, wbCyc, wbStb, wbWe, wbAck, pwmOut, pol;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatI, wbDatO, rdVal;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];
	int          fails, cmpCount, seed, per, dty, hi;

	pwmt_channel_timer dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .pwmOut(pwmOut));

	task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("compares=%0d mismatches=%0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wbCycle(input logic we, input logic [7:0] a, d);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= we;
		wbSel <= 4'hF;
		wbAdr <= a;
		wbDatI <= {24'h000000, d};
		@(posedge ref_clk);
		while (wbAck !== 1'h1) @(posedge ref_clk);
		rdVal = wbDatO;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		wbWe <= 1'h0;
		@(posedge ref_clk);
	endtask

	task automatic wbRead(input logic [7:0] a, input logic [31:0] e, m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		wbCycle(1'h0, a, 8'h00);
	endtask

	// a window of whole periods holds the same high count at any phase
	task automatic measure(input int p, input int expHi);
		hi = 0;
		repeat (3 * p) @(posedge ref_clk);
		repeat (4 * p) begin
			@(posedge ref_clk);
			hi += int'(pwmOut === 1'h1);
		end
		cmpVal(32'(hi), 32'(4 * expHi));
	endtask

	always @(posedge ref_clk) begin
		if (wbAck === 1'h1 && wbWe === 1'h0 && expQ.size() > 0)
			cmpVal(wbDatO & mskQ.pop_front(), expQ.pop_front());
	end

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		final_report();
	end

	initial begin
		resetn = 1'h0;
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
		wbSel = 4'hF;
		seed = 32'hadcd;
		fails = 0;
		cmpCount = 0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		cmpVal({31'h0, pwmOut}, 32'h0);
		wbRead(8'h00, 32'h0, 32'hFFFF_FFFF);
		wbRead(8'h10, 32'h0, 32'h0000_0006);
		wbRead(8'h18, 32'h0, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) begin
			per = 2 + ($unsigned($random(seed)) % 40);
			dty = 1 + ($unsigned($random(seed)) % (per - 1));
			pol = i[0];
			wbCycle(1'h1, 8'h00, 8'h00);
			wbCycle(1'h1, 8'h04, 8'(per));
			wbCycle(1'h1, 8'h08, 8'(dty));
			wbRead(8'h08, 32'(dty), 32'hFFFF_FFFF);
			wbCycle(1'h1, 8'h0C, 8'h5A);
			wbRead(8'h0C, 32'h0, 32'h0000_00FF);
			wbCycle(1'h1, 8'h00, {6'h00, pol, 1'h1});
			measure(per, pol ? dty : per - dty);
			wbCycle(1'h0, 8'h0C, 8'h00);
			cmpVal(32'(rdVal[7:0] < per), 32'h1);
		end
		wbCycle(1'h1, 8'h00, 8'h00);
		wbCycle(1'h1, 8'h04, 8'hC8);
		wbCycle(1'h1, 8'h08, 8'h64);
		wbCycle(1'h1, 8'h0C, 8'h00);
		wbCycle(1'h1, 8'h00, 8'h03);
		wbCycle(1'h1, 8'h08, 8'h96);
		repeat (110) @(posedge ref_clk);
		cmpVal({31'h0, pwmOut}, 32'h0);
		measure(200, 150);
		wbCycle(1'h1, 8'h00, 8'h00);
		wbCycle(1'h0, 8'h0C, 8'h00);
		repeat (5) @(posedge ref_clk);
		wbRead(8'h0C, rdVal, 32'hFFFF_FFFF);
		wbCycle(1'h1, 8'h04, 8'h00);
		repeat (3) @(posedge ref_clk);
		wbRead(8'h0C, 32'h0, 32'hFFFF_FFFF);
		wbCycle(1'h1, 8'h14, 8'h03);
		wbCycle(1'h1, 8'h04, 8'h0A);
		wbCycle(1'h1, 8'h08, 8'h03);
		wbCycle(1'h1, 8'h0C, 8'h00);
		wbCycle(1'h1, 8'h00, 8'h01);
		measure(40, 28);
		wbCycle(1'h1, 8'h00, 8'h00);
		wbCycle(1'h1, 8'h14, 8'h00);
		wbCycle(1'h1, 8'h00, 8'h04);
		wbCycle(1'h1, 8'h0C, 8'h00);
		wbCycle(1'h1, 8'h00, 8'h05);
		pol = 1'h0;
		repeat (20) begin
			wbCycle(1'h0, 8'h10, 8'h00);
			pol |= rdVal[1];
		end
		cmpVal({31'h0, pol}, 32'h1);
		final_report();
	end
endmodule

bind pwmt_channel_timer pwmt_channel_timer_monitor mon_u (
	.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pwmOut(pwmOut));
